// *** rtl/dcp_consts.svh ***
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH

// -----------------------------------------------------------------
// Register indices; byte address is four times the index.
// -----------------------------------------------------------------
`define DCP_IDX_CTRL 6'h00
`define DCP_IDX_GAIN_A 6'h03
`define DCP_IDX_GAIN_B 6'h04
`define DCP_IDX_WATCH_L 6'h05
`define DCP_IDX_WATCH_R 6'h06
`define DCP_IDX_ROUTE 6'h07
`define DCP_IDX_STATUS 6'h08
`define DCP_IDX_GAIN_C 6'h0F
`define DCP_IDX_GAIN_D 6'h10
`define DCP_IDX_GAIN_H 6'h14

// -----------------------------------------------------------------
// Reset values and levels.
// -----------------------------------------------------------------
`define DCP_CTRL_RST 7'h01
`define DCP_GAIN_RST 8'hFF
`define DCP_GAIN_MUTE 8'h00
`define DCP_FINE_BITS 4
`define DCP_STEPS_PER_OCT 8'h0C
`define DCP_MANT_SHIFT 6'h10
`define DCP_ZERO_FRAMES 8192
`define DCP_FLAG_HOLD 3'h4
`define DCP_SNAP_FRAMES 3'h5
`define DCP_STEP_M0 12'h001
`define DCP_STEP_M1 12'h002
`define DCP_STEP_M2 12'h008
`define DCP_STEP_M3 12'h010
`define DCP_NEG_MAX 32'h80000000
`define DCP_POS_MAX 32'h7FFFFFFF

`endif

// *** rtl/dcp_pkg.sv ***
package dcp_pkg;

  // -----------------------------------------------------------------
  // Shared types.
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCP_FLT_SHARP = 2'h0,
    DCP_FLT_ALT = 2'h1,
    DCP_FLT_SUPER_SLOW = 2'h2,
    DCP_FLT_SLOW = 2'h3
  } dcp_filter_t;

  typedef struct packed {
    logic rolloff_gentlest_sel;
    logic rolloff_slow_sel;
    logic zero_pol;
    logic [1:0] ramp_rate_sel;
    logic reserved;
    logic soft_reset_n;
  } dcp_ctrl_t;

  typedef struct packed {
    logic single_source_sel;
    logic source_side_sel;
    logic left_phase_flip;
    logic right_phase_flip;
  } dcp_route_t;

  typedef struct packed {
    logic [7:0][31:0] ch;
  } dcp_frame_t;

  typedef struct packed {
    logic [3:0][31:0] left;
    logic [3:0][31:0] right;
  } dcp_out_t;

endpackage : dcp_pkg

// *** rtl/dcp_top.sv ***
// Notes on behaviour
// - Two select bits choose sharp, alternate, slow or super-slow filter.
// - Each of eight channels has its own zero-watch enable bit.
// - 8192 all-zero frames on watched channels raise the zero flag.
// - Any nonzero watched sample clears the flag at once.
// - Soft reset low forces the zero flag pin high.
// - After soft reset release the flag drops after three to four frames.
// - A polarity bit inverts the zero flag pin.
// - With no watched channel the flag shows the zero level only in soft reset and the hold after it.
// - Every channel has its own 256-level attenuator in 0.5dB steps.
// - Code FFH is 0dB, each step down 0.5dB, code 00H mutes.
// - Ramp field selects 4080, 2040, 510 or 255 frame transitions.
// - All four codes ramp gradually between gain settings.
// - Default rate walks 4080 fine levels from FFH to 00H.
// - Power-down input low resets every gain code to FFH.
// - Gain written during soft reset applies at once, with no ramp.
// - Gain changed within five frames after release applies at once.
// - Route bits pick straight, swapped, left-mono or right-mono sources.
// - Flip bits invert left and right outputs after routing.
// - Routing and flipping act the same for every input format.
`include "dcp_consts.svh"

module dcp_top #(
  parameter int ZERO_FRAMES = `DCP_ZERO_FRAMES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_clock,
  input wire logic power_down_n,
  input wire dcp_pkg::dcp_frame_t sample_in,
  output dcp_pkg::dcp_out_t analog_outputs,
  output logic sample_valid,
  output logic zero_flag_out,
  output dcp_pkg::dcp_filter_t filter_mode
);

  // -----------------------------------------------------------------
  // Input synchronisers.
  // -----------------------------------------------------------------
  logic fc_s1, fc_s2, fc_s3, pdn_s1, pdn_s2;
  dcp_pkg::dcp_frame_t smp_s1, smp_s2;
  logic frame_stb;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_s1 <= 1'b0;
      fc_s2 <= 1'b0;
      fc_s3 <= 1'b0;
      pdn_s1 <= 1'b0;
      pdn_s2 <= 1'b0;
      smp_s1 <= '0;
      smp_s2 <= '0;
    end else begin
      fc_s1 <= frame_clock;
      fc_s2 <= fc_s1;
      fc_s3 <= fc_s2;
      pdn_s1 <= power_down_n;
      pdn_s2 <= pdn_s1;
      smp_s1 <= sample_in;
      smp_s2 <= smp_s1;
    end
  end

  assign frame_stb = fc_s2 & ~fc_s3;

  // -----------------------------------------------------------------
  // Register file.
  // -----------------------------------------------------------------
  dcp_pkg::dcp_ctrl_t ctrl, next_ctrl;
  logic [3:0] watch_l, watch_r, next_watch_l, next_watch_r;
  logic [3:0][3:0] route, next_route;
  logic [7:0][7:0] gain, next_gain;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [5:0] idx;
  logic wr_acc, rd_set;
  logic [7:0] det, busy;

  assign idx = paddr[7:2];
  assign wr_acc = psel & penable & pwrite;
  assign rd_set = psel & ~penable;
  assign pready = 1'b1;

  always_comb begin
    next_ctrl = ctrl;
    next_watch_l = watch_l;
    next_watch_r = watch_r;
    next_route = route;
    next_gain = gain;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (rd_set) begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      if (idx == `DCP_IDX_CTRL) begin
        next_prdata[6:0] = ctrl;
      end else if (idx == `DCP_IDX_GAIN_A) begin
        next_prdata[7:0] = gain[0];
      end else if (idx == `DCP_IDX_GAIN_B) begin
        next_prdata[7:0] = gain[1];
      end else if (idx == `DCP_IDX_WATCH_L) begin
        next_prdata[3:0] = watch_l;
      end else if (idx == `DCP_IDX_WATCH_R) begin
        next_prdata[3:0] = watch_r;
      end else if (idx == `DCP_IDX_ROUTE) begin
        next_prdata[15:0] = route;
      end else if (idx == `DCP_IDX_STATUS) begin
        next_prdata[16:0] = {zero_flag_out, busy, det};
      end else if (idx >= `DCP_IDX_GAIN_C && idx <= `DCP_IDX_GAIN_H) begin
        next_prdata[7:0] = gain[3'(idx - `DCP_IDX_GAIN_C) + 3'h2];
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (wr_acc) begin
      if (idx == `DCP_IDX_CTRL) begin
        next_ctrl = pwdata[6:0];
      end else if (idx == `DCP_IDX_GAIN_A) begin
        next_gain[0] = pwdata[7:0];
      end else if (idx == `DCP_IDX_GAIN_B) begin
        next_gain[1] = pwdata[7:0];
      end else if (idx == `DCP_IDX_WATCH_L) begin
        next_watch_l = pwdata[3:0];
      end else if (idx == `DCP_IDX_WATCH_R) begin
        next_watch_r = pwdata[3:0];
      end else if (idx == `DCP_IDX_ROUTE) begin
        next_route = pwdata[15:0];
      end else if (idx >= `DCP_IDX_GAIN_C && idx <= `DCP_IDX_GAIN_H) begin
        next_gain[3'(idx - `DCP_IDX_GAIN_C) + 3'h2] = pwdata[7:0];
      end
    end
    if (!pdn_s2) begin
      next_gain = {8{`DCP_GAIN_RST}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `DCP_CTRL_RST;
      watch_l <= '0;
      watch_r <= '0;
      route <= '0;
      gain <= {8{`DCP_GAIN_RST}};
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      watch_l <= next_watch_l;
      watch_r <= next_watch_r;
      route <= next_route;
      gain <= next_gain;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign filter_mode = dcp_pkg::dcp_filter_t'(
    {ctrl.rolloff_gentlest_sel, ctrl.rolloff_slow_sel});

  // -----------------------------------------------------------------
  // Frames since soft reset release.
  // -----------------------------------------------------------------
  logic [2:0] rel_cnt, next_rel_cnt;
  logic snap;

  always_comb begin
    next_rel_cnt = rel_cnt;
    if (!ctrl.soft_reset_n) begin
      next_rel_cnt = '0;
    end else if (frame_stb && rel_cnt != `DCP_SNAP_FRAMES) begin
      next_rel_cnt = rel_cnt + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt <= '0;
    end else begin
      rel_cnt <= next_rel_cnt;
    end
  end

  assign snap = !ctrl.soft_reset_n || rel_cnt != `DCP_SNAP_FRAMES;

  // -----------------------------------------------------------------
  // Volume ramp, zero counters and output path per channel.
  // -----------------------------------------------------------------
  function automatic logic [16:0] dcp_mant(input logic [3:0] k);
    case (k)
      4'h0: dcp_mant = 17'h10000;
      4'h1: dcp_mant = 17'h0F1AE;
      4'h2: dcp_mant = 17'h0E429;
      4'h3: dcp_mant = 17'h0D766;
      4'h4: dcp_mant = 17'h0CB59;
      4'h5: dcp_mant = 17'h0BFF9;
      4'h6: dcp_mant = 17'h0B53C;
      4'h7: dcp_mant = 17'h0AB19;
      4'h8: dcp_mant = 17'h0A186;
      4'h9: dcp_mant = 17'h0987D;
      4'hA: dcp_mant = 17'h08FF5;
      default: dcp_mant = 17'h087E8;
    endcase
  endfunction : dcp_mant

  function automatic logic [31:0] dcp_scale(input logic [31:0] s,
                                            input logic [7:0] code);
    logic [7:0] a;
    logic [5:0] sh;
    logic signed [49:0] p;
    a = `DCP_GAIN_RST - code;
    sh = 6'(a / `DCP_STEPS_PER_OCT) + `DCP_MANT_SHIFT;
    p = $signed(s) * $signed({1'b0, dcp_mant(4'(a % `DCP_STEPS_PER_OCT))});
    p = p >>> sh;
    dcp_scale = (code == `DCP_GAIN_MUTE) ? '0 : p[31:0];
  endfunction : dcp_scale

  function automatic logic [31:0] dcp_flip(input logic [31:0] s,
                                           input logic en);
    if (!en) begin
      dcp_flip = s;
    end else if (s == `DCP_NEG_MAX) begin
      dcp_flip = `DCP_POS_MAX;
    end else begin
      dcp_flip = -s;
    end
  endfunction : dcp_flip

  logic [11:0] step;
  logic [7:0][11:0] lvl, next_lvl;
  logic [7:0][13:0] zcnt, next_zcnt;
  logic [7:0][31:0] routed;
  logic [7:0] watch;
  dcp_pkg::dcp_out_t next_out;

  always_comb begin
    case (ctrl.ramp_rate_sel)
      2'h0: step = `DCP_STEP_M0;
      2'h1: step = `DCP_STEP_M1;
      2'h2: step = `DCP_STEP_M2;
      default: step = `DCP_STEP_M3;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      logic [11:0] tgt;
      logic [31:0] src, pick;
      dcp_pkg::dcp_route_t rt;
      assign tgt = {pdn_s2 ? gain[g] : `DCP_GAIN_RST, `DCP_FINE_BITS'(0)};
      assign rt = route[g / 2];
      assign watch[g] = (g % 2 == 0) ? watch_l[g / 2] : watch_r[g / 2];
      assign busy[g] = lvl[g] != tgt;
      assign det[g] = zcnt[g] == 14'(ZERO_FRAMES);

      always_comb begin
        next_lvl[g] = lvl[g];
        if (!pdn_s2 || snap) begin
          next_lvl[g] = tgt;
        end else if (frame_stb && lvl[g] < tgt) begin
          next_lvl[g] = tgt - lvl[g] > step ? lvl[g] + step : tgt;
        end else if (frame_stb && lvl[g] > tgt) begin
          next_lvl[g] = lvl[g] - tgt > step ? lvl[g] - step : tgt;
        end
        next_zcnt[g] = zcnt[g];
        if (!ctrl.soft_reset_n || (frame_stb && smp_s2.ch[g] != '0)) begin
          next_zcnt[g] = '0;
        end else if (frame_stb && !det[g]) begin
          next_zcnt[g] = zcnt[g] + 14'h1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lvl[g] <= {`DCP_GAIN_RST, `DCP_FINE_BITS'(0)};
          zcnt[g] <= '0;
        end else begin
          lvl[g] <= next_lvl[g];
          zcnt[g] <= next_zcnt[g];
        end
      end

      always_comb begin
        if (rt.single_source_sel) begin
          src = rt.source_side_sel ? smp_s2.ch[(g / 2) * 2 + 1]
                                   : smp_s2.ch[(g / 2) * 2];
        end else begin
          src = rt.source_side_sel ? smp_s2.ch[g ^ 1] : smp_s2.ch[g];
        end
        pick = dcp_flip(src, (g % 2 == 0) ? rt.left_phase_flip
                                          : rt.right_phase_flip);
        routed[g] = dcp_scale(pick, lvl[g][11:4]);
      end

      if (g % 2 == 0) begin : g_l
        assign next_out.left[g / 2] = frame_stb ? routed[g]
                                                : analog_outputs.left[g / 2];
      end else begin : g_r
        assign next_out.right[g / 2] = frame_stb ? routed[g]
                                                 : analog_outputs.right[g / 2];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_outputs <= '0;
      sample_valid <= 1'b0;
    end else begin
      analog_outputs <= next_out;
      sample_valid <= frame_stb;
    end
  end

  // -----------------------------------------------------------------
  // Zero flag.
  // -----------------------------------------------------------------
  logic zero_all, next_flag;

  assign zero_all = (|watch) && ((det | ~watch) == 8'hFF);

  always_comb begin
    if (!ctrl.soft_reset_n || rel_cnt < `DCP_FLAG_HOLD) begin
      next_flag = 1'b1;
    end else begin
      next_flag = zero_all ^ ctrl.zero_pol;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_flag_out <= 1'b1;
    end else begin
      zero_flag_out <= next_flag;
    end
  end

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_flag_rst;
    !ctrl.soft_reset_n |=> zero_flag_out;
  endproperty
  a_flag_rst: assert property (p_flag_rst)
    else $error("zero flag not high in soft reset");

  property p_flag_hold;
    $rose(ctrl.soft_reset_n) |-> zero_flag_out [*3];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("zero flag dropped too early");

  property p_no_watch;
    ctrl.soft_reset_n && rel_cnt == `DCP_SNAP_FRAMES && watch == '0
      |=> zero_flag_out == $past(ctrl.zero_pol);
  endproperty
  a_no_watch: assert property (p_no_watch)
    else $error("zero flag shows zero with no watched channel");

  property p_zero_seen;
    ctrl.soft_reset_n && rel_cnt == `DCP_SNAP_FRAMES && zero_all
      |=> zero_flag_out == !$past(ctrl.zero_pol);
  endproperty
  a_zero_seen: assert property (p_zero_seen)
    else $error("zero flag missing after zero run");

  property p_nonzero;
    frame_stb && smp_s2.ch[0] != '0 |=> zcnt[0] == '0 ##1 !det[0];
  endproperty
  a_nonzero: assert property (p_nonzero)
    else $error("zero count not cleared by data");

  property p_pdn_gain;
    !pdn_s2 |=> gain == {8{`DCP_GAIN_RST}} && lvl[0] == 12'hFF0;
  endproperty
  a_pdn_gain: assert property (p_pdn_gain)
    else $error("gain not reset in power down");

  property p_snap;
    pdn_s2 && snap |=> lvl[0] == {$past(gain[0]), 4'h0};
  endproperty
  a_snap: assert property (p_snap)
    else $error("gain not applied at once near reset");

  property p_ramp;
    pdn_s2 && !snap && frame_stb && busy[0] && ctrl.ramp_rate_sel == 2'h0
      |=> lvl[0] - $past(lvl[0]) == 12'h001
       || $past(lvl[0]) - lvl[0] == 12'h001;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp did not move one fine step");

endmodule : dcp_top

// *** bench/dcp_frame_src.sv ***
module dcp_frame_src (
  input wire logic run,
  input wire dcp_pkg::dcp_frame_t next_frame,
  output logic frame_clock,
  output dcp_pkg::dcp_frame_t sample_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Frame source
  // ---------------------------------------------------------------
  // The frame clock has an 80 ns period.
  // Samples change mid low phase so they are steady around each rise.
  initial begin
    frame_clock = 1'b0;
    sample_in = '0;
  end

  always begin
    #40;
    frame_clock = run ? ~frame_clock : 1'b0;
  end

  always @(negedge frame_clock) begin
    #20;
    sample_in = next_frame;
  end
endmodule : dcp_frame_src

// *** bench/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [31:0] d;
    logic cd;
    logic er;
  } dcp_rd_t;
  typedef struct packed {
    dcp_pkg::dcp_out_t o;
    logic fc;
    logic fl;
    logic [1:0] fm;
  } dcp_fx_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic power_down_n = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frame_clock;
  logic sample_valid;
  logic zero_flag_out;
  dcp_pkg::dcp_frame_t sample_in;
  dcp_pkg::dcp_frame_t nf = '0;
  dcp_pkg::dcp_frame_t fr;
  dcp_pkg::dcp_out_t aout;
  dcp_pkg::dcp_filter_t fmode;
  dcp_rd_t rq[$];
  dcp_fx_t oq[$];
  dcp_rd_t rc;
  dcp_fx_t xc;
  int failures = 0;
  int checks_done = 0;
  int vcount = 0;
  int c0;
  int ex;
  logic [31:0] seed = 32'h000115D6;
  logic [31:0] q;
  logic [15:0] rt = 16'h0000;
  logic [1:0] fm_now = 2'h0;
  logic fc_now = 1'b1;
  logic fl_now = 1'b0;
  logic m0 = 1'b0;

  always #5 pclk = ~pclk;

  dcp_top #(.ZERO_FRAMES(16)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_clock(frame_clock), .power_down_n(power_down_n),
    .sample_in(sample_in), .analog_outputs(aout),
    .sample_valid(sample_valid), .zero_flag_out(zero_flag_out),
    .filter_mode(fmode)
  );

  dcp_frame_src u_src (
    .run(1'b1), .next_frame(nf), .frame_clock(frame_clock),
    .sample_in(sample_in)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [255:0] s,
                       input logic [255:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check

  function automatic logic [31:0] neg(input logic [31:0] x);
    return (x === 32'h80000000) ? 32'h7FFFFFFF : 32'h0 - x;
  endfunction : neg

  function automatic dcp_pkg::dcp_out_t route(
    input dcp_pkg::dcp_frame_t f, input logic [15:0] r);
    dcp_pkg::dcp_out_t o;
    logic [3:0] n;
    logic [31:0] a;
    logic [31:0] b;
    for (int k = 0; k < 4; k++) begin
      n = r[4*k +: 4];
      a = n[2] ? f.ch[2*k+1] : f.ch[2*k];
      b = (n[3] ? n[2] : ~n[2]) ? f.ch[2*k+1] : f.ch[2*k];
      o.left[k] = n[1] ? neg(a) : a;
      o.right[k] = n[0] ? neg(b) : b;
    end
    return o;
  endfunction : route

  function automatic dcp_pkg::dcp_frame_t rnd();
    dcp_pkg::dcp_frame_t f;
    for (int k = 0; k < 8; k++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      f.ch[k] = seed;
    end
    return f;
  endfunction : rnd

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic cd,
                     input logic [31:0] e, input logic er);
    rq.push_back('{e, cd, er});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b1, e, 1'b0);
  endtask : rd

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge pclk);
      while (sample_valid !== 1'b1) @(posedge pclk);
    end
  endtask : frames

  task automatic fchk(input dcp_pkg::dcp_frame_t f, input int skip);
    dcp_pkg::dcp_out_t e;
    nf = f;
    frames(skip);
    e = route(f, rt);
    if (m0) e.left[0] = '0;
    oq.push_back('{e, fc_now, fl_now, fm_now});
    while (oq.size() != 0) @(posedge pclk);
    @(posedge pclk);
  endtask : fchk

  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // Monitors
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (sample_valid === 1'b1) vcount++;
    if (psel && penable && pready && rq.size() != 0) begin
      rc = rq.pop_front();
      if (rc.cd) check("read data", prdata, rc.d);
      check("slave error", pslverr, rc.er);
    end
  end

  always @(negedge pclk) begin
    if (sample_valid === 1'b1 && oq.size() != 0) begin
      xc = oq.pop_front();
      check("outputs", aout, xc.o);
      check("filter", fmode, xc.fm);
      @(negedge pclk);
      if (xc.fc) check("zero flag", zero_flag_out, xc.fl);
    end
  end

  initial begin
    #500000;
    failures++;
    close_out();
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h01);
    for (int k = 0; k < 8; k++) rd(8'((k < 2 ? 3 + k : 13 + k) * 4), 32'hFF);
    apb(1'b0, 8'h04, 32'h0, 1'b1, 32'h0, 1'b1);
    apb(1'b1, 8'hFC, 32'h5, 1'b0, 32'h0, 1'b1);
    frames(8);
    for (int f = 0; f < 4; f++) begin
      wr(8'h00, 32'h1 | 32'(f << 5));
      fm_now = 2'(f);
      fchk(rnd(), 2);
    end
    wr(8'h00, 32'h1);
    fm_now = 2'h0;
    for (int r = 0; r < 16; r++) begin
      rt = {4{4'(r)}};
      wr(8'h1C, {16'h0, rt});
      fr = rnd();
      fr.ch[0] = 32'h80000000;
      fchk(fr, 2);
    end
    rt = 16'h0;
    wr(8'h1C, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'h1 | 32'(s << 2));
      c0 = vcount;
      wr(8'h0C, s[0] ? 32'hFF : 32'hF7);
      do apb(1'b0, 8'h20, 32'h0, 1'b0, 32'h0, 1'b0);
      while (q[8] === 1'b1);
      ex = 128 >> (s == 0 ? 0 : s == 1 ? 1 : s + 1);
      c0 = vcount - c0;
      check("ramp", c0 >= ex - 1 && c0 <= ex + 1, 1);
    end
    wr(8'h00, 32'h0);
    fl_now = 1'b1;
    wr(8'h0C, 32'h40);
    rd(8'h0C, 32'h40);
    power_down_n <= 1'b0;
    frames(2);
    rd(8'h0C, 32'hFF);
    power_down_n <= 1'b1;
    repeat (2) @(posedge pclk);
    wr(8'h0C, 32'h0);
    m0 = 1'b1;
    fchk(rnd(), 2);
    wr(8'h00, 32'h1);
    wr(8'h0C, 32'hFF);
    m0 = 1'b0;
    fc_now = 1'b0;
    fchk(rnd(), 2);
    frames(6);
    fc_now = 1'b1;
    fl_now = 1'b0;
    wr(8'h14, 32'h1);
    fchk('0, 2);
    fl_now = 1'b1;
    fchk('0, 18);
    fr = '0;
    fr.ch[1] = seed | 32'h1;
    fchk(fr, 2);
    wr(8'h00, 32'h11);
    fl_now = 1'b0;
    fchk(fr, 2);
    fr.ch[0] = 32'h1;
    fl_now = 1'b1;
    fchk(fr, 2);
    wr(8'h00, 32'h10);
    fchk('0, 18);
    nf = fr;
    frames(2);
    wr(8'h00, 32'h1);
    fl_now = 1'b0;
    fchk(fr, 8);
    wr(8'h14, 32'h0);
    fchk('0, 20);
    wr(8'h18, 32'h1);
    fl_now = 1'b1;
    fchk('0, 20);
    close_out();
  end
endmodule : tb
